// ---- logic/gated_process_timer.v ----
`timescale 1ns/100ps
`include "gated_process_timer_consts.vh"
// Behaviour
// RULE_01: A mode field picks inactive, interval, weekly, or weekly with runtime.
// RULE_02: When supply returns the timer stops, continues or restarts as set.
// RULE_03: After the hh:mm:ss interval expires the active output value appears.
// RULE_04: A lead delay of 0 to 65535 seconds precedes the interval.
// RULE_05: An after-run of up to 32767 seconds follows the interval.
// RULE_06: An after-run setting of minus one never ends by itself.
// RULE_07: Quit ends the after-run only when the after-run setting is above 0.
// RULE_08: Start begins a run; a retrigger is taken only after lead and interval.
// RULE_09: Stop resets the timer; hold freezes it without losing elapsed time.
// RULE_10: Restart during lead or interval resets and begins a new run at once.
// RULE_11: Polarity high passes the output, polarity low inverts it.
// RULE_12: The timer starts and runs only while the deviation is within window.
// RULE_13: Deviation beyond the window freezes a run and blocks a new start.
// RULE_14: With logging on, each start turn-on records an entry with its text.
// RULE_15: Weekly mode has four on and four off times per weekday.
// RULE_16: All counters advance on a one-second tick; the interval counter is frozen by hold or window, the weekly runtime counter only by supply loss.
// RULE_17: The active value stands from expiry until after-run ends or reset.
module gated_process_timer #(
  parameter SEC_DIV = `SEC_DIV_CYCLES,
  parameter AW = 24
) (
  input wire clk_i,
  input wire rst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire hready_i,
  input wire [31:0] hwdata_i,
  output wire hreadyout_o,
  output wire hresp_o,
  output reg [31:0] hrdata_o,
  input wire start_i,
  input wire stop_i,
  input wire hold_i,
  input wire restart_i,
  input wire quit_i,
  input wire signed [AW-1:0] x_i,
  input wire signed [AW-1:0] w_i,
  input wire power_fail_i,
  input wire [2:0] day_i,
  input wire [16:0] tod_i,
  output reg out_o,
  output reg event_o,
  output reg [167:0] event_text_o,
  output wire irq_o
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_LEAD = 4'b0010;
  localparam ST_RUN = 4'b0100;
  localparam ST_AFTER = 4'b1000;

  reg [31:0] ctrl_reg;
  reg [23:0] time_reg;
  reg [15:0] lead_reg;
  reg [15:0] after_reg;
  reg [`WINDOW_W-1:0] window_reg;
  reg [`STATUS_W-1:0] status_reg;
  reg [`STATUS_W-1:0] mask_reg;
  reg [23:0] runtime_reg;
  reg [31:0] text_mem [0:`TEXT_WORDS-1];
  reg [16:0] week_mem [0:`WEEK_WORDS-1];
  reg [3:0] st_reg;
  reg [3:0] st_next;
  reg [19:0] cnt_reg;
  reg [19:0] cnt_next;
  reg start_prev_reg;
  reg pfail_prev_reg;
  reg [16:0] tod_prev_reg;
  reg wk_on_reg;
  reg wk_on_next;
  reg [19:0] wk_cnt_reg;
  reg [19:0] wk_cnt_next;
  reg wr_pend_reg;
  reg [8:0] waddr_reg;
  reg [31:0] rdata_next;
  reg [`STATUS_W-1:0] ev_set;
  reg expire_ev;
  reg end_ev;
  reg active_next;
  wire sec_tick;
  wire [1:0] mode = ctrl_reg[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
  wire [1:0] recov = ctrl_reg[`CTRL_RECOV_LSB+1:`CTRL_RECOV_LSB];
  wire pol_high = ctrl_reg[`CTRL_POL_BIT];
  wire log_en = ctrl_reg[`CTRL_LOG_BIT];

  second_tick #(.DIV(SEC_DIV)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(sec_tick)
  );

  function [19:0] to_sec;
    input [23:0] hms;
    begin
      to_sec = {12'h0, hms[`HH_LSB+7:`HH_LSB]} * `SEC_PER_HR
             + {12'h0, hms[`MM_LSB+7:`MM_LSB]} * `SEC_PER_MIN
             + {12'h0, hms[`SS_LSB+7:`SS_LSB]};
    end
  endfunction

  // Window check on the sign-extended difference
  wire signed [AW:0] diff = {x_i[AW-1], x_i} - {w_i[AW-1], w_i};
  wire [AW:0] adiff = diff[AW] ? (~diff + 1'b1) : diff;
  wire in_win = adiff <= {{(AW+1-`WINDOW_W){1'b0}}, window_reg}; // [RULE_12]

  wire start_rise = start_i & ~start_prev_reg;
  wire pf_return = pfail_prev_reg & ~power_fail_i;
  // Hold, window and supply loss all freeze the interval counter cnt_reg
  wire tick_ok = sec_tick & ~hold_i & in_win & ~power_fail_i; // [RULE_16] [RULE_09] [RULE_13]
  wire [19:0] lead_t = {4'h0, lead_reg};
  wire [19:0] run_t = to_sec(time_reg);
  wire [19:0] after_t = {4'h0, after_reg};
  wire after_inf = after_reg == `AFTER_INFINITE;
  wire quit_ok = quit_i & ~after_reg[15] & (after_reg != 16'h0); // [RULE_07]
  wire [19:0] cnt_inc = tick_ok ? cnt_reg + 20'h1 : cnt_reg;

  always @* begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    expire_ev = 1'b0;
    end_ev = 1'b0;
    case (st_reg)
      ST_IDLE: begin
        if (start_rise & in_win) begin // [RULE_08] [RULE_13]
          st_next = ST_LEAD;
          cnt_next = 20'h0;
        end
      end
      ST_LEAD: begin
        if (restart_i) begin // [RULE_10]
          cnt_next = 20'h0;
        end else if (cnt_reg >= lead_t) begin // [RULE_04]
          st_next = ST_RUN;
          cnt_next = 20'h0;
        end else begin
          cnt_next = cnt_inc;
        end
      end
      ST_RUN: begin
        if (restart_i) begin // [RULE_10]
          st_next = ST_LEAD;
          cnt_next = 20'h0;
        end else if (cnt_reg >= run_t) begin // [RULE_03]
          st_next = ST_AFTER;
          cnt_next = 20'h0;
          expire_ev = 1'b1;
        end else begin
          cnt_next = cnt_inc;
        end
      end
      ST_AFTER: begin
        if (quit_ok) begin // [RULE_07]
          st_next = ST_IDLE;
          end_ev = 1'b1;
        end else if (start_rise & in_win) begin // [RULE_08]
          st_next = ST_LEAD;
          cnt_next = 20'h0;
        end else if (~after_inf & (cnt_reg >= after_t)) begin // [RULE_05] [RULE_06]
          st_next = ST_IDLE;
          end_ev = 1'b1;
        end else begin
          cnt_next = cnt_inc;
        end
      end
      default: begin
        st_next = ST_IDLE;
        cnt_next = 20'h0;
      end
    endcase
    if (pf_return) begin // [RULE_02]
      if (recov == `RECOV_STOP) begin
        st_next = ST_IDLE;
        cnt_next = 20'h0;
      end else if (recov == `RECOV_RESTART && st_reg != ST_IDLE) begin
        st_next = ST_LEAD;
        cnt_next = 20'h0;
      end
    end
    if (stop_i | (mode != `MODE_INTERVAL)) begin // [RULE_09] [RULE_01]
      st_next = ST_IDLE;
      cnt_next = 20'h0;
    end
  end

  // Weekly switching, evaluated once per new second of the day
  wire [5:0] day_base = {day_i, 3'b000};
  wire tod_new = tod_i != tod_prev_reg;
  wire [3:0] on_hit;
  wire [3:0] off_hit;
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_sw
      assign on_hit[k] = tod_new &
        (week_mem[day_base + k] == tod_i); // [RULE_15]
      assign off_hit[k] = tod_new &
        (week_mem[day_base + 4 + k] == tod_i); // [RULE_15]
    end
  endgenerate

  always @* begin
    wk_on_next = wk_on_reg;
    wk_cnt_next = wk_cnt_reg;
    if (mode == `MODE_WEEKLY) begin
      if (|on_hit) begin
        wk_on_next = 1'b1;
      end else if (|off_hit) begin
        wk_on_next = 1'b0;
      end
    end else if (mode == `MODE_WEEKLY_RT) begin
      if (|on_hit) begin
        wk_on_next = 1'b1;
        wk_cnt_next = 20'h0;
      end else if (wk_on_reg) begin
        if (wk_cnt_reg >= to_sec(runtime_reg)) begin // [RULE_15]
          wk_on_next = 1'b0;
        end else if (sec_tick & ~power_fail_i) begin
          wk_cnt_next = wk_cnt_reg + 20'h1;
        end
      end
    end else begin
      wk_on_next = 1'b0;
    end
    if (mode == `MODE_INTERVAL) begin // [RULE_01]
      active_next = st_next == ST_AFTER; // [RULE_17]
    end else begin
      active_next = wk_on_next;
    end
  end

  always @* begin
    ev_set = {`STATUS_W{1'b0}};
    ev_set[`ST_START_BIT] = start_rise & log_en;
    ev_set[`ST_EXPIRE_BIT] = expire_ev;
    ev_set[`ST_END_BIT] = end_ev;
    ev_set[`ST_POWER_BIT] = pf_return;
    ev_set[`ST_WEEK_BIT] = wk_on_next & ~wk_on_reg;
  end

  // Bus slave: zero wait states, reads registered in the address phase
  wire addr_ok = hsel_i & htrans_i[1] & hready_i;
  wire rd_take = addr_ok & ~hwrite_i;
  wire [8:0] raddr = {haddr_i[8:2], 2'b00};
  wire rd_status = rd_take & (raddr == `OFS_STATUS);
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign irq_o = |(status_reg & mask_reg);

  always @* begin
    rdata_next = 32'h0;
    if (raddr >= `OFS_WEEK && raddr < `OFS_WEEK + 4 * `WEEK_WORDS) begin
      rdata_next = {15'h0, week_mem[raddr[7:2]]};
    end else if (raddr >= `OFS_TEXT &&
                 raddr < `OFS_TEXT + 4 * `TEXT_WORDS) begin
      rdata_next = text_mem[raddr[4:2]];
    end else begin
      case (raddr)
        `OFS_CTRL: rdata_next = ctrl_reg;
        `OFS_TIME: rdata_next = {8'h0, time_reg};
        `OFS_LEAD: rdata_next = {16'h0, lead_reg};
        `OFS_AFTER: rdata_next = {{16{after_reg[15]}}, after_reg};
        `OFS_WINDOW: rdata_next = {15'h0, window_reg};
        `OFS_STATUS: rdata_next = {27'h0, status_reg};
        `OFS_MASK: rdata_next = {27'h0, mask_reg};
        `OFS_STATE: rdata_next = {6'h0, wk_on_reg, out_o, st_reg, cnt_reg};
        `OFS_RUNTIME: rdata_next = {8'h0, runtime_reg};
        default: rdata_next = 32'h0;
      endcase
    end
  end

  wire wr_week = wr_pend_reg & (waddr_reg >= `OFS_WEEK) &
    (waddr_reg < `OFS_WEEK + 4 * `WEEK_WORDS);
  wire wr_text = wr_pend_reg & (waddr_reg >= `OFS_TEXT) &
    (waddr_reg < `OFS_TEXT + 4 * `TEXT_WORDS);
  wire [167:0] text_flat = {text_mem[5][7:0], text_mem[4], text_mem[3],
    text_mem[2], text_mem[1], text_mem[0]};

  integer i;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= `CTRL_RESET;
      time_reg <= 24'h0;
      lead_reg <= 16'h0;
      after_reg <= 16'h0;
      window_reg <= {`WINDOW_W{1'b0}};
      mask_reg <= {`STATUS_W{1'b0}};
      runtime_reg <= 24'h0;
      for (i = 0; i < `TEXT_WORDS; i = i + 1) begin
        text_mem[i] <= 32'h0;
      end
      for (i = 0; i < `WEEK_WORDS; i = i + 1) begin
        week_mem[i] <= 17'h0;
      end
      wr_pend_reg <= 1'b0;
      waddr_reg <= 9'h0;
    end else begin
      wr_pend_reg <= addr_ok & hwrite_i;
      waddr_reg <= raddr;
      if (wr_week) begin
        week_mem[waddr_reg[7:2]] <= hwdata_i[16:0];
      end else if (wr_text) begin
        text_mem[waddr_reg[4:2]] <= hwdata_i;
      end else if (wr_pend_reg) begin
        case (waddr_reg)
          `OFS_CTRL: ctrl_reg <= hwdata_i;
          `OFS_TIME: time_reg <= hwdata_i[23:0];
          `OFS_LEAD: lead_reg <= hwdata_i[15:0];
          `OFS_AFTER: after_reg <= hwdata_i[15:0];
          `OFS_WINDOW: window_reg <= hwdata_i[`WINDOW_W-1:0];
          `OFS_MASK: mask_reg <= hwdata_i[`STATUS_W-1:0];
          `OFS_RUNTIME: runtime_reg <= hwdata_i[23:0];
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= ST_IDLE;
      cnt_reg <= 20'h0;
      start_prev_reg <= 1'b0;
      pfail_prev_reg <= 1'b0;
      tod_prev_reg <= 17'h0;
      wk_on_reg <= 1'b0;
      wk_cnt_reg <= 20'h0;
      status_reg <= {`STATUS_W{1'b0}};
      hrdata_o <= 32'h0;
      out_o <= 1'b0;
      event_o <= 1'b0;
      event_text_o <= 168'h0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      start_prev_reg <= start_i;
      pfail_prev_reg <= power_fail_i;
      tod_prev_reg <= tod_i;
      wk_on_reg <= wk_on_next;
      wk_cnt_reg <= wk_cnt_next;
      // Fresh events survive a clearing read
      status_reg <= (rd_status ? {`STATUS_W{1'b0}} : status_reg) | ev_set;
      if (rd_take) begin
        hrdata_o <= rdata_next;
      end
      out_o <= pol_high ? active_next : ~active_next; // [RULE_11] [RULE_17]
      event_o <= start_rise & log_en; // [RULE_14]
      if (start_rise & log_en) begin
        event_text_o <= text_flat; // [RULE_14]
      end
    end
  end
endmodule

// ---- logic/gated_process_timer_consts.vh ----
`ifndef GATED_PROCESS_TIMER_CONSTS_VH
`define GATED_PROCESS_TIMER_CONSTS_VH

// Clock rate and one-second tick
`define CLK_HZ 25000000
`define CLK_PERIOD_NS 40
`define SEC_DIV_CYCLES (1000000000 / `CLK_PERIOD_NS)

// Byte offsets of the register map
`define OFS_CTRL 9'h000
`define OFS_TIME 9'h004
`define OFS_LEAD 9'h008
`define OFS_AFTER 9'h00c
`define OFS_WINDOW 9'h010
`define OFS_STATUS 9'h014
`define OFS_MASK 9'h018
`define OFS_STATE 9'h01c
`define OFS_RUNTIME 9'h020
`define OFS_TEXT 9'h040
`define OFS_WEEK 9'h100
`define TEXT_WORDS 6
`define WEEK_WORDS 56

// Control register fields
`define CTRL_MODE_LSB 0
`define CTRL_RECOV_LSB 2
`define CTRL_POL_BIT 4
`define CTRL_LOG_BIT 5
`define CTRL_RESET 32'h0000_0010

// Operating modes
`define MODE_OFF 2'h0
`define MODE_INTERVAL 2'h1
`define MODE_WEEKLY 2'h2
`define MODE_WEEKLY_RT 2'h3

// Recovery after supply loss
`define RECOV_STOP 2'h0
`define RECOV_CONTINUE 2'h1
`define RECOV_RESTART 2'h2

// Status / mask bits
`define ST_START_BIT 0
`define ST_EXPIRE_BIT 1
`define ST_END_BIT 2
`define ST_POWER_BIT 3
`define ST_WEEK_BIT 4
`define STATUS_W 5

// Time fields hh:mm:ss
`define HH_LSB 16
`define MM_LSB 8
`define SS_LSB 0
`define SEC_PER_HR 20'he10
`define SEC_PER_MIN 20'h3c
`define AFTER_INFINITE 16'hffff
`define WINDOW_W 17

`endif

// ---- logic/second_tick.v ----
`timescale 1ns/100ps
module second_tick #(
  parameter DIV = 25000000
) (
  input wire clk_i,
  input wire rst_i,
  output reg tick_o
);
  reg [31:0] cnt_reg;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_reg == DIV - 1) begin
      cnt_reg <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule

// ---- verif/gated_process_timer_chk.sv ----
`timescale 1ns/100ps
module gated_process_timer_chk (
  input wire clk_i,
  input wire rst_i,
  input wire hsel_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire hready_i,
  input wire hreadyout_o,
  input wire [31:0] hrdata_o,
  input wire start_i,
  input wire stop_i,
  input wire hold_i,
  input wire restart_i,
  input wire quit_i,
  input wire power_fail_i,
  input wire out_o,
  input wire event_o,
  input wire [167:0] event_text_o,
  input wire irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Three cycles, so a move already due before the freeze is excused
  sequence held_still;
    (hold_i && !stop_i && !restart_i && !quit_i) [*3];
  endsequence
  sequence no_supply;
    (power_fail_i && !stop_i && !restart_i && !quit_i) [*3];
  endsequence
  ready_a: assert property (hreadyout_o)
    else $error("hreadyout dropped");
  rdata_hold_a: assert property (!(hsel_i && htrans_i[1] && !hwrite_i
    && hready_i) |=> $stable(hrdata_o)) else $error("hrdata moved");
  event_pulse_a: assert property (event_o |=> !event_o)
    else $error("event wider than a cycle");
  event_cause_a: assert property (event_o |-> $past(start_i)
    && !$past(start_i, 2)) else $error("event without start edge");
  text_hold_a: assert property (
    !event_o |-> $stable(event_text_o)) else $error("text moved");
  hold_freeze_a: assert property (held_still |-> $stable(out_o))
    else $error("output moved under hold");
  power_freeze_a: assert property (no_supply |-> $stable(out_o))
    else $error("output moved without supply");
  stop_idle_a: assert property (stop_i [*3] |-> $stable(out_o))
    else $error("output moved under stop");
  reset_out_a: assert property ($fell(rst_i) |-> !out_o && !irq_o)
    else $error("output active after reset");
endmodule

// ---- verif/signal_selector_model.sv ----
`timescale 1ns/100ps
module signal_selector_model (
  input wire clk_i,
  input wire [4:0] bin_sel_i,
  input wire signed [23:0] x_sel_i,
  input wire signed [23:0] w_sel_i,
  output reg start_o,
  output reg stop_o,
  output reg hold_o,
  output reg restart_o,
  output reg quit_o,
  output reg signed [23:0] x_o,
  output reg signed [23:0] w_o
);
  // Selectors republish their sources once a clock, never sooner
  always @(posedge clk_i) begin
    {quit_o, restart_o, hold_o, stop_o, start_o} <= bin_sel_i;
    x_o <= x_sel_i;
    w_o <= w_sel_i;
  end
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
`include "gated_process_timer_consts.vh"
module tb_top;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg [4:0] cmd = 5'h0;
  reg signed [23:0] xv = 24'h0;
  reg signed [23:0] wv = 24'h0;
  reg pf = 1'b0;
  reg [2:0] day = 3'h0;
  reg [16:0] tod = 17'h0;
  reg ev_seen = 1'b0;
  reg [31:0] rv;
  wire rdy, resp, out, ev, irq, st, sp, hd, rs, qt;
  wire [31:0] rdata;
  wire [167:0] txt;
  wire signed [23:0] xs, ws;
  integer bad_count = 0;
  integer total_checks = 0;
  integer cyc = 0;
  integer n;
  always #20 clk_i = ~clk_i;
  // One second is eight clocks here
  gated_process_timer #(.SEC_DIV(8)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(rdy),
    .hwdata_i(hwdata), .hreadyout_o(rdy), .hresp_o(resp), .hrdata_o(rdata),
    .start_i(st), .stop_i(sp), .hold_i(hd), .restart_i(rs), .quit_i(qt),
    .x_i(xs), .w_i(ws), .power_fail_i(pf), .day_i(day), .tod_i(tod),
    .out_o(out), .event_o(ev), .event_text_o(txt), .irq_o(irq));
  signal_selector_model u_sel (.clk_i(clk_i), .bin_sel_i(cmd),
    .x_sel_i(xv), .w_sel_i(wv), .start_o(st), .stop_o(sp), .hold_o(hd),
    .restart_o(rs), .quit_o(qt), .x_o(xs), .w_o(ws));
  task complete_run;
    begin
      if (bad_count == 0 && total_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (ev)
      ev_seen <= 1'b1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("Error %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task bus(input [8:0] a, input w, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= {23'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk_i);
      while (!rdy) @(posedge clk_i);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk_i);
      while (!rdy) @(posedge clk_i);
      rv = rdata;
    end
  endtask
  task pulse(input [4:0] b);
    begin
      cmd <= cmd | b;
      @(posedge clk_i);
      cmd <= cmd & ~b;
      @(posedge clk_i);
    end
  endtask
  task wait_out(input v);
    begin
      n = 0;
      while (out !== v) begin
        @(posedge clk_i);
        n = n + 1;
      end
    end
  endtask
  task span(input string nm, input integer lo, input integer hi);
    chk(nm, {31'h0, n >= lo && n <= hi}, 32'h1);
  endtask
  // Short supply loss, then three clocks for the return to act
  task blip;
    begin
      pf <= 1'b1;
      repeat (4) @(posedge clk_i);
      pf <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask
  task state_is(input [3:0] s);
    begin
      bus(`OFS_STATE, 0, 0);
      chk("state", {28'h0, rv[23:20]}, {28'h0, s});
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(`OFS_CTRL, 0, 0);
    chk("ctrl", rv, `CTRL_RESET);
    bus(9'h024, 0, 0);
    chk("unmapped", rv, 32'h0);
    chk("resp", {31'h0, resp}, 32'h0);
    bus(`OFS_TIME, 1, 32'h2);
    bus(`OFS_LEAD, 1, 32'h3);
    bus(`OFS_AFTER, 1, 32'h2);
    bus(`OFS_WINDOW, 1, 32'h5);
    bus(`OFS_MASK, 1, 32'h2);
    bus(`OFS_TEXT, 1, 32'h41424344);
    bus(`OFS_CTRL, 1, 32'h31);
    pulse(5'h1);
    wait_out(1'b1);
    span("lead_run", 22, 48);
    chk("irq", {31'h0, irq}, 32'h1);
    chk("event", {31'h0, ev_seen}, 32'h1);
    chk("text", txt[31:0], 32'h41424344);
    wait_out(1'b0);
    span("after", 6, 20);
    bus(`OFS_STATUS, 0, 0);
    chk("status", rv, 32'h7);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    pulse(5'h1);
    repeat (20) @(posedge clk_i);
    pulse(5'h8);
    wait_out(1'b1);
    span("restart", 24, 48);
    wait_out(1'b0);
    pulse(5'h1);
    repeat (10) @(posedge clk_i);
    cmd <= 5'h2;
    repeat (60) @(posedge clk_i);
    cmd <= 5'h0;
    chk("stop", {31'h0, out}, 32'h0);
    state_is(4'h1);
    cmd <= 5'h4;
    @(posedge clk_i);
    pulse(5'h1);
    repeat (80) @(posedge clk_i);
    chk("hold", {31'h0, out}, 32'h0);
    state_is(4'h2);
    cmd <= 5'h0;
    wait_out(1'b1);
    wait_out(1'b0);
    xv <= 24'sh64;
    wv <= 24'sh6e;
    pulse(5'h1);
    repeat (60) @(posedge clk_i);
    state_is(4'h1);
    xv <= 24'sh6c;
    pulse(5'h1);
    repeat (12) @(posedge clk_i);
    xv <= 24'sh64;
    repeat (80) @(posedge clk_i);
    chk("window", {31'h0, out}, 32'h0);
    xv <= 24'sh69;
    wait_out(1'b1);
    span("window_edge", 1, 48);
    wait_out(1'b0);
    bus(`OFS_AFTER, 1, 32'hffff);
    bus(`OFS_AFTER, 0, 0);
    chk("after_rd", rv, 32'hffffffff);
    pulse(5'h1);
    wait_out(1'b1);
    repeat (100) @(posedge clk_i);
    pulse(5'h10);
    repeat (2) @(posedge clk_i);
    chk("endless", {31'h0, out}, 32'h1);
    pulse(5'h2);
    repeat (2) @(posedge clk_i);
    chk("stop_after", {31'h0, out}, 32'h0);
    bus(`OFS_AFTER, 1, 32'h1e);
    pulse(5'h1);
    wait_out(1'b1);
    repeat (8) @(posedge clk_i);
    pulse(5'h10);
    repeat (2) @(posedge clk_i);
    chk("quit", {31'h0, out}, 32'h0);
    bus(`OFS_CTRL, 1, 32'h21);
    repeat (2) @(posedge clk_i);
    chk("pol_low", {31'h0, out}, 32'h1);
    bus(`OFS_CTRL, 1, 32'h20);
    pulse(5'h1);
    repeat (60) @(posedge clk_i);
    chk("mode_off", {31'h0, out}, 32'h1);
    bus(`OFS_CTRL, 1, 32'h31);
    pulse(5'h1);
    repeat (8) @(posedge clk_i);
    pf <= 1'b1;
    repeat (100) @(posedge clk_i);
    chk("supply_off", {31'h0, out}, 32'h0);
    pf <= 1'b0;
    repeat (3) @(posedge clk_i);
    state_is(4'h1);
    bus(`OFS_CTRL, 1, 32'h35);
    pulse(5'h1);
    wait_out(1'b1);
    blip;
    state_is(4'h8);
    pulse(5'h2);
    bus(`OFS_CTRL, 1, 32'h39);
    pulse(5'h1);
    wait_out(1'b1);
    blip;
    state_is(4'h2);
    chk("recov_out", {31'h0, out}, 32'h0);
    // Day 2 uses table words 16 to 23
    bus(9'h140, 1, 32'h64);
    bus(9'h150, 1, 32'h6e);
    bus(9'h140, 0, 0);
    chk("week_rd", rv, 32'h64);
    bus(`OFS_CTRL, 1, 32'h12);
    day <= 3'h2;
    tod <= 17'h64;
    repeat (2) @(posedge clk_i);
    chk("week_on", {31'h0, out}, 32'h1);
    tod <= 17'h6e;
    repeat (2) @(posedge clk_i);
    chk("week_off", {31'h0, out}, 32'h0);
    bus(`OFS_RUNTIME, 1, 32'h1);
    bus(`OFS_CTRL, 1, 32'h13);
    tod <= 17'h64;
    repeat (2) @(posedge clk_i);
    chk("rt_on", {31'h0, out}, 32'h1);
    wait_out(1'b0);
    span("runtime", 1, 12);
    complete_run;
  end
endmodule
bind gated_process_timer gated_process_timer_chk u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
  .hrdata_o(hrdata_o), .start_i(start_i), .stop_i(stop_i),
  .hold_i(hold_i), .restart_i(restart_i), .quit_i(quit_i),
  .power_fail_i(power_fail_i), .out_o(out_o), .event_o(event_o),
  .event_text_o(event_text_o), .irq_o(irq_o));
